//--- src/pifr_flag_regs.sv
// Device end: peripheral interrupt flag registers with software port
//
// Functional notes
// - Two flag registers, one bit per source
// - Flags set regardless of any enable bit
// - Software clears flags before enable, after service
// - Parallel port access sets flag until cleared
// - Conversion done sets flag until cleared
// - Receive flag clears when receive buffer read
// - Transmit flag set empty, cleared on write
// - Sync serial completion sets flag until cleared
// - Capture or compare match sets first flag
// - Timer two period match sets its flag
// - Timer one overflow sets its flag
// - Small package: parallel port flag reads zero
// - Peripheral enable also needed without priority levels
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module pifr_flag_regs #(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	pifr_periph_if.dev                         evt,
	input  wire logic [pifr_pkg::ADDR_W-1:0]   addr,
	input  wire logic [pifr_pkg::DATA_W-1:0]   wdata,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	output logic      [pifr_pkg::DATA_W-1:0]   rdata_q,
	output logic      [pifr_pkg::DATA_W-1:0]   flags_a_q,
	output logic      [pifr_pkg::DATA_W-1:0]   flags_b_q,
	output logic                               irq_q
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [pifr_pkg::DATA_W-1:0] flags_a_d;
	logic [pifr_pkg::DATA_W-1:0] flags_b_d;
	logic [pifr_pkg::DATA_W-1:0] set_a;
	logic [pifr_pkg::DATA_W-1:0] set_b;
	logic [pifr_pkg::DATA_W-1:0] writable_a;
	logic [pifr_pkg::STAT_W-1:0] status_q;
	logic [pifr_pkg::STAT_W-1:0] status_d;
	logic [pifr_pkg::STAT_W-1:0] enable_q;
	logic [pifr_pkg::STAT_W-1:0] stat_set;
	logic [pifr_pkg::STAT_W-1:0] stat_clr;
	logic                        wr_a;
	logic                        wr_b;
	logic                        wr_en_reg;
	logic                        wr_clear;
	logic                        rx_d;
	logic                        tx_d;

	// ****************************************************************
	// Shared helpers
	// ****************************************************************
	function automatic logic hit(
		input logic                        strobe,
		input logic [pifr_pkg::ADDR_W-1:0] a,
		input logic [pifr_pkg::ADDR_W-1:0] target
	);
		hit = strobe && (a == target);
	endfunction : hit

	// A software write replaces the writable bits; a hardware set in the
	// same cycle still wins, so no event is lost to a racing clear
	function automatic logic [pifr_pkg::DATA_W-1:0] flag_next(
		input logic [pifr_pkg::DATA_W-1:0] q,
		input logic [pifr_pkg::DATA_W-1:0] set,
		input logic                        wr,
		input logic [pifr_pkg::DATA_W-1:0] data,
		input logic [pifr_pkg::DATA_W-1:0] writable
	);
		logic [pifr_pkg::DATA_W-1:0] kept;
		kept = wr ? ((data & writable) | (q & ~writable)) : q;
		flag_next = kept | set;
	endfunction : flag_next

	// ****************************************************************
	// Write decode
	// ****************************************************************
	assign wr_a      = hit(wr_en, addr, pifr_pkg::ADDR_FLAGS_A);
	assign wr_b      = hit(wr_en, addr, pifr_pkg::ADDR_FLAGS_B);
	assign wr_en_reg = hit(wr_en, addr, pifr_pkg::ADDR_IRQ_EN);
	assign wr_clear  = hit(wr_en, addr, pifr_pkg::ADDR_IRQ_CLEAR);

	// ****************************************************************
	// Set vectors
	// ****************************************************************
	// Sources set their flag with no regard to any enable bit
	always_comb begin
		set_a = pifr_pkg::FLAGS_RST;
		set_a[pifr_pkg::BIT_PARPORT]  = evt.parport_evt & ~SMALL_PACKAGE;
		set_a[pifr_pkg::BIT_CONV]     = evt.conv_done_evt;
		set_a[pifr_pkg::BIT_SYNC]     = evt.sync_done_evt;
		set_a[pifr_pkg::BIT_CAPCOMP1] = evt.capcomp_one_evt;
		set_a[pifr_pkg::BIT_TIMER_TWO_COUNT]     = evt.timer_two_match_evt;
		set_a[pifr_pkg::BIT_TIMER_ONE_COUNT]     = evt.timer_one_ovf_evt;
	end

	assign set_b = evt.set_b;

	// The parallel port bit is neither set nor written on the small part
	always_comb begin
		writable_a = pifr_pkg::WRITABLE_A;
		if (SMALL_PACKAGE) begin
			writable_a[pifr_pkg::BIT_PARPORT] = 1'b0;
		end
	end

	// ****************************************************************
	// Serial buffer flags
	// ****************************************************************
	// A new load beats a read in the same cycle: the buffer then holds
	// the fresh byte, so the flag must stay up
	assign rx_d = evt.rx_loaded | (flags_a_q[pifr_pkg::BIT_RX] & ~evt.rx_read);
	// Reset leaves the flag low until the transmitter reports empty
	assign tx_d = evt.tx_emptied | (flags_a_q[pifr_pkg::BIT_TX] & ~evt.tx_written);

	// ****************************************************************
	// Flag registers
	// ****************************************************************
	always_comb begin
		flags_a_d = flag_next(flags_a_q, set_a, wr_a, wdata, writable_a);
		flags_a_d[pifr_pkg::BIT_RX] = rx_d;
		flags_a_d[pifr_pkg::BIT_TX] = tx_d;
		flags_b_d = flag_next(flags_b_q, set_b, wr_b, wdata, pifr_pkg::WRITABLE_B);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_a_q <= pifr_pkg::FLAGS_RST;
		end else begin
			flags_a_q <= flags_a_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_b_q <= pifr_pkg::FLAGS_RST;
		end else begin
			flags_b_q <= flags_b_d;
		end
	end

	// ****************************************************************
	// Interrupt status and enable
	// ****************************************************************
	// Status notes any new flag event per register; the individual flag
	// still has to be cleared in the flag register itself
	always_comb begin
		stat_set = pifr_pkg::STAT_RST;
		stat_set[pifr_pkg::STAT_A] = (|set_a) | evt.rx_loaded | evt.tx_emptied;
		stat_set[pifr_pkg::STAT_B] = |set_b;
		stat_clr = wr_clear ? wdata[pifr_pkg::STAT_W-1:0] : pifr_pkg::STAT_RST;
		status_d = (status_q & ~stat_clr) | stat_set;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			status_q <= pifr_pkg::STAT_RST;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			enable_q <= pifr_pkg::STAT_RST;
		end else if (wr_en_reg) begin
			enable_q <= wdata[pifr_pkg::STAT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & enable_q);
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Data stand one cycle after the strobe and only then; unmapped and
	// write-only addresses read zero
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_q <= pifr_pkg::FLAGS_RST;
		end else if (!rd_en) begin
			rdata_q <= pifr_pkg::FLAGS_RST;
		end else begin
			unique case (addr)
				pifr_pkg::ADDR_FLAGS_A: rdata_q <= flags_a_q;
				pifr_pkg::ADDR_FLAGS_B: rdata_q <= flags_b_q;
				pifr_pkg::ADDR_IRQ_STAT: rdata_q <= {{(pifr_pkg::DATA_W-pifr_pkg::STAT_W){1'b0}},
					status_q};
				pifr_pkg::ADDR_IRQ_EN: rdata_q <= {{(pifr_pkg::DATA_W-pifr_pkg::STAT_W){1'b0}},
					enable_q};
				default: rdata_q <= pifr_pkg::FLAGS_RST;
			endcase
		end
	end

endmodule : pifr_flag_regs

//--- common/pifr_pkg.sv
// Shared constants and types for the peripheral interrupt flag registers
package pifr_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int STAT_W = 2;

	// ****************************************************************
	// Software register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_A   = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_B   = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 3'h4;

	// ****************************************************************
	// Field positions of periph_irq_flags_a
	// ****************************************************************
	localparam int BIT_PARPORT  = 7;
	localparam int BIT_CONV     = 6;
	localparam int BIT_RX       = 5;
	localparam int BIT_TX       = 4;
	localparam int BIT_SYNC     = 3;
	localparam int BIT_CAPCOMP1 = 2;
	localparam int BIT_TIMER_TWO_COUNT     = 1;
	localparam int BIT_TIMER_ONE_COUNT     = 0;

	// ****************************************************************
	// Field positions of periph_irq_flags_b
	// ****************************************************************
	localparam int BIT_OSC      = 7;
	localparam int BIT_CMP1     = 6;
	localparam int BIT_CMP2     = 5;
	localparam int BIT_NVW      = 4;
	localparam int BIT_BUSCOL   = 3;
	localparam int BIT_VDET     = 2;
	localparam int BIT_TMR3     = 1;
	localparam int BIT_CAPCOMP2 = 0;

	// ****************************************************************
	// Status bits, write masks and reset values
	// ****************************************************************
	localparam int STAT_A = 0;
	localparam int STAT_B = 1;
	localparam logic [DATA_W-1:0] WRITABLE_A = 8'hcf;
	localparam logic [DATA_W-1:0] WRITABLE_B = 8'hff;
	localparam logic [DATA_W-1:0] FLAGS_RST  = 8'h00;
	localparam logic [STAT_W-1:0] STAT_RST   = 2'h0;

	typedef enum logic [1:0] {
		PIFR_CC_CAPTURE,
		PIFR_CC_COMPARE,
		PIFR_CC_PWM
	} pifr_cc_mode_t;

endpackage : pifr_pkg

//--- common/pifr_periph_if.sv
// Event link from the peripherals to the flag registers
`timescale 1ns/1ps
interface pifr_periph_if;
	logic                          parport_evt;
	logic                          conv_done_evt;
	logic                          sync_done_evt;
	logic                          capcomp_one_evt;
	logic                          timer_two_match_evt;
	logic                          timer_one_ovf_evt;
	logic                          rx_loaded;
	logic                          rx_read;
	logic                          tx_emptied;
	logic                          tx_written;
	logic [pifr_pkg::DATA_W-1:0]   set_b;

	modport dev (
		input parport_evt, conv_done_evt, sync_done_evt, capcomp_one_evt,
		input timer_two_match_evt, timer_one_ovf_evt,
		input rx_loaded, rx_read, tx_emptied, tx_written, set_b
	);
	modport periph (
		output parport_evt, conv_done_evt, sync_done_evt, capcomp_one_evt,
		output timer_two_match_evt, timer_one_ovf_evt,
		output rx_loaded, rx_read, tx_emptied, tx_written, set_b
	);
endinterface : pifr_periph_if

//--- src/pifr_periph_events.sv
// Peripheral end: registers raw peripheral conditions as event pulses; only comparator, voltage and timer two levels are edge-detected
`timescale 1ns/1ps
module pifr_periph_events (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	input  wire logic                          parport_access,
	input  wire logic                          conv_done,
	input  wire logic                          sync_done,
	input  wire pifr_pkg::pifr_cc_mode_t       capcomp_one_mode,
	input  wire logic                          capcomp_one_capture,
	input  wire logic                          capcomp_one_match,
	input  wire logic [pifr_pkg::DATA_W-1:0]   timer_two_count,
	input  wire logic [pifr_pkg::DATA_W-1:0]   timer_two_period,
	input  wire logic                          timer_one_overflow,
	input  wire logic                          rx_data_loaded,
	input  wire logic                          rx_buffer_read,
	input  wire logic                          tx_data_moved,
	input  wire logic                          tx_buffer_write,
	input  wire logic                          osc_failed,
	input  wire logic                          comparator_one_out,
	input  wire logic                          comparator_two_out,
	input  wire logic                          nv_write_done,
	input  wire logic                          bus_collision,
	input  wire logic                          voltage_above,
	input  wire logic                          voltage_direction_select,
	input  wire logic                          timer_three_overflow,
	input  wire pifr_pkg::pifr_cc_mode_t       capcomp_two_mode,
	input  wire logic                          capcomp_two_capture,
	input  wire logic                          capcomp_two_match,
	pifr_periph_if.periph                      evt
);

	// ****************************************************************
	// Level history for change detection
	// ****************************************************************
	logic primed_q;
	logic cmp1_q;
	logic cmp2_q;
	logic volt_q;
	logic t2_eq_q;
	logic t2_eq;

	assign t2_eq = (timer_two_count == timer_two_period);

	// Comparator and voltage levels are only compared once a first sample exists, so a high
	// comparator at reset release raises no false change event
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			primed_q <= 1'b0;
			cmp1_q   <= 1'b0;
			cmp2_q   <= 1'b0;
			volt_q   <= 1'b0;
			t2_eq_q  <= 1'b0;
		end else begin
			primed_q <= 1'b1;
			cmp1_q   <= comparator_one_out;
			cmp2_q   <= comparator_two_out;
			volt_q   <= voltage_above;
			t2_eq_q  <= t2_eq;
		end
	end

	// ****************************************************************
	// Capture/compare event selection
	// ****************************************************************
	function automatic logic cc_event(
		input pifr_pkg::pifr_cc_mode_t mode,
		input logic                    capture,
		input logic                    match
	);
		unique case (mode)
			pifr_pkg::PIFR_CC_CAPTURE: cc_event = capture;
			pifr_pkg::PIFR_CC_COMPARE: cc_event = match;
			pifr_pkg::PIFR_CC_PWM:     cc_event = 1'b0;
			default:                   cc_event = 1'b0;
		endcase
	endfunction : cc_event

	// ****************************************************************
	// Registered event pulses
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			evt.parport_evt         <= 1'b0;
			evt.conv_done_evt       <= 1'b0;
			evt.sync_done_evt       <= 1'b0;
			evt.capcomp_one_evt     <= 1'b0;
			evt.timer_two_match_evt <= 1'b0;
			evt.timer_one_ovf_evt   <= 1'b0;
			evt.rx_loaded           <= 1'b0;
			evt.rx_read             <= 1'b0;
			evt.tx_emptied          <= 1'b0;
			evt.tx_written          <= 1'b0;
			evt.set_b               <= pifr_pkg::FLAGS_RST;
		end else begin
			evt.parport_evt         <= parport_access;
			evt.conv_done_evt       <= conv_done;
			evt.sync_done_evt       <= sync_done;
			evt.capcomp_one_evt     <= cc_event(capcomp_one_mode, capcomp_one_capture,
				capcomp_one_match);
			evt.timer_two_match_evt <= t2_eq & ~t2_eq_q;
			evt.timer_one_ovf_evt   <= timer_one_overflow;
			evt.rx_loaded           <= rx_data_loaded;
			evt.rx_read             <= rx_buffer_read;
			evt.tx_emptied          <= tx_data_moved;
			evt.tx_written          <= tx_buffer_write;
			evt.set_b[pifr_pkg::BIT_OSC]      <= osc_failed;
			evt.set_b[pifr_pkg::BIT_CMP1]     <= primed_q & (comparator_one_out ^ cmp1_q);
			evt.set_b[pifr_pkg::BIT_CMP2]     <= primed_q & (comparator_two_out ^ cmp2_q);
			evt.set_b[pifr_pkg::BIT_NVW]      <= nv_write_done;
			evt.set_b[pifr_pkg::BIT_BUSCOL]   <= bus_collision;
			// Direction select high: event on rising above the trip point
			evt.set_b[pifr_pkg::BIT_VDET]     <= primed_q & (voltage_direction_select ?
				(voltage_above & ~volt_q) : (~voltage_above & volt_q));
			evt.set_b[pifr_pkg::BIT_TMR3]     <= timer_three_overflow;
			evt.set_b[pifr_pkg::BIT_CAPCOMP2] <= cc_event(capcomp_two_mode,
				capcomp_two_capture, capcomp_two_match);
		end
	end

endmodule : pifr_periph_events

//--- testbench/pifr_chk.sv
// Concurrent checks on the event link and the flag outputs
`timescale 1ns/1ps
module pifr_chk (
	input wire logic                        sys_clk,
	input wire logic                        rst_n,
	input wire logic                        parport_evt,
	input wire logic                        conv_done_evt,
	input wire logic                        sync_done_evt,
	input wire logic                        capcomp_one_evt,
	input wire logic                        timer_two_match_evt,
	input wire logic                        timer_one_ovf_evt,
	input wire logic                        rx_loaded,
	input wire logic                        rx_read,
	input wire logic                        tx_emptied,
	input wire logic                        tx_written,
	input wire logic [pifr_pkg::DATA_W-1:0] set_b,
	input wire logic [pifr_pkg::DATA_W-1:0] flags_a_q,
	input wire logic [pifr_pkg::DATA_W-1:0] flags_b_q
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking

	// A load in the same cycle wins over the buffer access
	sequence s_rx_drop; rx_read && !rx_loaded; endsequence
	sequence s_tx_drop; tx_written && !tx_emptied; endsequence

	chk_reset_clears: assert property (!rst_n |=> (flags_a_q == 8'h00) && (flags_b_q == 8'h00))
		else $error("flags not zero after reset");
	chk_parport_sets: assert property (disable iff (!rst_n) parport_evt |=> flags_a_q[7])
		else $error("parallel port flag not set");
	chk_conv_sets: assert property (disable iff (!rst_n) conv_done_evt |=> flags_a_q[6])
		else $error("conversion flag not set");
	chk_sync_sets: assert property (disable iff (!rst_n) sync_done_evt |=> flags_a_q[3])
		else $error("sync serial flag not set");
	chk_capcomp_sets: assert property (disable iff (!rst_n) capcomp_one_evt |=> flags_a_q[2])
		else $error("capture compare flag not set");
	chk_timer_two_count_sets: assert property (disable iff (!rst_n) timer_two_match_evt |=> flags_a_q[1])
		else $error("timer two flag not set");
	chk_timer_one_count_sets: assert property (disable iff (!rst_n) timer_one_ovf_evt |=> flags_a_q[0])
		else $error("timer one flag not set");
	chk_rx_sets: assert property (disable iff (!rst_n) rx_loaded |=> flags_a_q[5])
		else $error("receive flag not set");
	chk_rx_drops: assert property (disable iff (!rst_n) s_rx_drop |=> !flags_a_q[5])
		else $error("receive flag not cleared");
	chk_tx_sets: assert property (disable iff (!rst_n) tx_emptied |=> flags_a_q[4])
		else $error("transmit flag not set");
	chk_tx_drops: assert property (disable iff (!rst_n) s_tx_drop |=> !flags_a_q[4])
		else $error("transmit flag not cleared");
	chk_b_sticky_set: assert property (disable iff (!rst_n) (set_b != 8'h00) |=>
		((flags_b_q & $past(set_b)) == $past(set_b))) else $error("second register flag not set");
endmodule : pifr_chk

//--- testbench/peripheral_irq_flag_regs_test.sv
// Self-checking bench for both ends of the interrupt flag link
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module peripheral_irq_flag_regs_test;
	logic                    sys_clk, rst_n, cmp1, cmp2, v_above, v_dir, wr_en, rd_en, irq_q;
	logic [15:0]             pulse;
	pifr_pkg::pifr_cc_mode_t cc1_mode, cc2_mode;
	logic [7:0]              t2_count, t2_period, wdata, rdata_q, flags_a_q, flags_b_q;
	logic [7:0]              exp_a, exp_b, w, flags_a_s;
	logic [2:0]              addr;
	int                      failures, n_compared, cycles;
	integer                  seed;
	int                      a_idx[4] = '{0, 1, 2, 5};
	int                      a_bit[4] = '{7, 6, 3, 0};
	int                      b_idx[5] = '{10, 11, 12, 13, 14};
	int                      b_bit[5] = '{7, 4, 3, 1, 0};

	pifr_periph_if link();
	pifr_periph_events u_pifr_periph_events (.sys_clk(sys_clk), .rst_n(rst_n),
		.parport_access(pulse[0]), .conv_done(pulse[1]), .sync_done(pulse[2]),
		.capcomp_one_mode(cc1_mode), .capcomp_one_capture(pulse[3]), .capcomp_one_match(pulse[4]),
		.timer_two_count(t2_count), .timer_two_period(t2_period), .timer_one_overflow(pulse[5]),
		.rx_data_loaded(pulse[6]), .rx_buffer_read(pulse[7]), .tx_data_moved(pulse[8]),
		.tx_buffer_write(pulse[9]), .osc_failed(pulse[10]), .comparator_one_out(cmp1),
		.comparator_two_out(cmp2), .nv_write_done(pulse[11]), .bus_collision(pulse[12]),
		.voltage_above(v_above), .voltage_direction_select(v_dir),
		.timer_three_overflow(pulse[13]), .capcomp_two_mode(cc2_mode),
		.capcomp_two_capture(pulse[14]), .capcomp_two_match(pulse[15]), .evt(link));
	pifr_flag_regs u_pifr_flag_regs (.sys_clk(sys_clk), .rst_n(rst_n), .evt(link), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .flags_a_q(flags_a_q),
		.flags_b_q(flags_b_q), .irq_q(irq_q));
	// Small package copy on the same link: its parallel port bit must stay zero
	pifr_flag_regs #(.SMALL_PACKAGE(1'b1)) u_pifr_flag_regs_small (.sys_clk(sys_clk),
		.rst_n(rst_n), .evt(link), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata_q(), .flags_a_q(flags_a_s), .flags_b_q(), .irq_q());
	pifr_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .parport_evt(link.parport_evt),
		.conv_done_evt(link.conv_done_evt), .sync_done_evt(link.sync_done_evt),
		.capcomp_one_evt(link.capcomp_one_evt), .timer_two_match_evt(link.timer_two_match_evt),
		.timer_one_ovf_evt(link.timer_one_ovf_evt), .rx_loaded(link.rx_loaded),
		.rx_read(link.rx_read), .tx_emptied(link.tx_emptied), .tx_written(link.tx_written),
		.set_b(link.set_b), .flags_a_q(flags_a_q), .flags_b_q(flags_b_q));

	// ****************************************************************
	// Clock, timeout and bus tasks
	// ****************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compared %0d, failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 `CHK(rdata_q, e)
	endtask : rd

	// One-cycle peripheral pulse, then time for the two register stages
	task automatic hit(input int idx);
		@(posedge sys_clk) pulse[idx] <= 1'b1;
		@(posedge sys_clk) pulse <= 16'h0000;
		repeat (3) @(posedge sys_clk);
	endtask : hit

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst_n, cmp1, cmp2, v_above, wr_en, rd_en} = 6'h00;
		v_dir = 1'b1;
		pulse = 16'h0000;
		cc1_mode = pifr_pkg::PIFR_CC_CAPTURE;
		cc2_mode = pifr_pkg::PIFR_CC_CAPTURE;
		{t2_count, t2_period, wdata, addr} = {8'h00, 8'h40, 8'h00, 3'h0};
		{exp_a, exp_b} = 16'h0000;
		seed = 32'hfd8d8dc8;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
		$display("reset test done");
		// All enables are still zero here, so each of the four flags this loop drives must set anyway
		for (int i = 0; i < 4; i++) begin
			hit(a_idx[i]);
			exp_a[a_bit[i]] = 1'b1;
			rd(pifr_pkg::ADDR_FLAGS_A, exp_a);
		end
		`CHK(flags_a_s, exp_a & ~(8'h01 << pifr_pkg::BIT_PARPORT))
		hit(3);
		exp_a[2] = 1'b1;
		rd(pifr_pkg::ADDR_FLAGS_A, exp_a);
		wr(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		@(posedge sys_clk) cc1_mode <= pifr_pkg::PIFR_CC_COMPARE;
		hit(3);
		rd(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		hit(4);
		rd(pifr_pkg::ADDR_FLAGS_A, 8'h04);
		wr(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		@(posedge sys_clk) cc1_mode <= pifr_pkg::PIFR_CC_PWM;
		hit(3);
		hit(4);
		@(posedge sys_clk) t2_count <= 8'h40;
		repeat (4) @(posedge sys_clk);
		rd(pifr_pkg::ADDR_FLAGS_A, 8'h02);
		$display("first register test done");
		for (int i = 0; i < 5; i++) begin
			hit(b_idx[i]);
			exp_b[b_bit[i]] = 1'b1;
			rd(pifr_pkg::ADDR_FLAGS_B, exp_b);
		end
		wr(pifr_pkg::ADDR_FLAGS_B, 8'h00);
		@(posedge sys_clk) cc2_mode <= pifr_pkg::PIFR_CC_COMPARE;
		hit(15);
		@(posedge sys_clk) cmp1 <= 1'b1;
		@(posedge sys_clk) cmp2 <= 1'b1;
		@(posedge sys_clk) v_above <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(pifr_pkg::ADDR_FLAGS_B, 8'h65);
		// Direction select low: only a fall below the trip point counts
		wr(pifr_pkg::ADDR_FLAGS_B, 8'h00);
		@(posedge sys_clk) v_dir <= 1'b0;
		@(posedge sys_clk) v_above <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(pifr_pkg::ADDR_FLAGS_B, 8'h04);
		$display("second register test done");
		exp_a = 8'h02;
		repeat (8) begin
			w = $random(seed);
			wr(pifr_pkg::ADDR_FLAGS_A, w);
			exp_a = (exp_a & ~pifr_pkg::WRITABLE_A) | (w & pifr_pkg::WRITABLE_A);
			rd(pifr_pkg::ADDR_FLAGS_A, exp_a);
			`CHK(flags_a_s, exp_a & ~(8'h01 << pifr_pkg::BIT_PARPORT))
			wr(pifr_pkg::ADDR_FLAGS_B, w);
			rd(pifr_pkg::ADDR_FLAGS_B, w);
		end
		wr(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		hit(6);
		wr(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		rd(pifr_pkg::ADDR_FLAGS_A, 8'h20);
		hit(7);
		hit(8);
		wr(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		rd(pifr_pkg::ADDR_FLAGS_A, 8'h10);
		hit(9);
		rd(pifr_pkg::ADDR_FLAGS_A, 8'h00);
		$display("serial test done");
		wr(pifr_pkg::ADDR_IRQ_CLEAR, 8'h03);
		wr(pifr_pkg::ADDR_IRQ_EN, 8'h00);
		rd(pifr_pkg::ADDR_IRQ_STAT, 8'h00);
		hit(1);
		wr(pifr_pkg::ADDR_IRQ_STAT, 8'h00);
		rd(pifr_pkg::ADDR_IRQ_STAT, 8'h01);
		`CHK(irq_q, 1'b0)
		wr(pifr_pkg::ADDR_IRQ_EN, 8'h01);
		rd(pifr_pkg::ADDR_IRQ_EN, 8'h01);
		`CHK(irq_q, 1'b1)
		wr(pifr_pkg::ADDR_IRQ_CLEAR, 8'h01);
		hit(10);
		rd(pifr_pkg::ADDR_IRQ_STAT, 8'h02);
		`CHK(irq_q, 1'b0)
		$display("interrupt test done");
		report_and_stop();
	end
endmodule : peripheral_irq_flag_regs_test
